// ==== rtl/qcac_pkg.sv ====
// Purpose: Shared constants for the quiet chopper amplitude configuration block
// Assumes: 125 MHz device clock, register word written and read through ports
// Notes: Field positions and reset values of the configuration word live here
`default_nettype none
package qcac_pkg;
    localparam logic [7:0] REG_OFFSET = 8'h70;
    localparam int OFS_LSB = 0;
    localparam int SLOPE_LSB = 8;
    localparam int FREQ_LSB = 16;
    localparam int AUTOSCALE_BIT = 18;
    localparam logic [7:0] OFS_RESET = 8'h24;
    localparam logic [7:0] SLOPE_RESET = 8'h00;
    localparam logic [1:0] FREQ_RESET = 2'h0;
    localparam logic AUTOSCALE_RESET = 1'b1;
    // PWM periods in clocks: 1024/2, 512/2, 410/2; code 01 alternates 342 and 341
    localparam logic [9:0] HALF_00 = 10'h200;
    localparam logic [9:0] HALF_01 = 10'h156;
    localparam logic [9:0] HALF_10 = 10'h100;
    localparam logic [9:0] HALF_11 = 10'h0CD;
    localparam logic [9:0] FULL_01 = 10'h2AB;
    localparam logic [7:0] AMP_MAX = 8'hFF;
    localparam logic [4:0] CS_FULL = 5'h1F;
    typedef enum logic [1:0] {FREQ_1024, FREQ_683, FREQ_512, FREQ_410} qcac_freq_type;
endpackage : qcac_pkg
`default_nettype wire

// ==== rtl/qcac_pwm_timer.sv ====
// Purpose: PWM period timer producing one-cycle cycle-start pulses
// Assumes: Single clock; a shorter selector code cuts the running period when its count exceeds the new length
// Notes: 683 clocks hold two periods, so code 01 alternates 342 and 341 clocks
`default_nettype none
module qcac_pwm_timer (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [1:0] i_freq_sel,
    output logic o_period_start
);
    logic [9:0] cnt_ff;
    logic [9:0] nxt_cnt;
    logic start_ff;
    logic nxt_start;
    logic [9:0] period_len;
    logic [9:0] limit_len;
    logic odd_ff;
    logic nxt_odd;

    // Period length per selector code
    always_comb
    begin
        unique case (qcac_pkg::qcac_freq_type'(i_freq_sel))
            qcac_pkg::FREQ_1024: period_len = qcac_pkg::HALF_00 - 10'd1;
            qcac_pkg::FREQ_683: period_len = odd_ff ? qcac_pkg::HALF_01 - 10'd2 : qcac_pkg::HALF_01 - 10'd1;
            qcac_pkg::FREQ_512: period_len = qcac_pkg::HALF_10 - 10'd1;
            qcac_pkg::FREQ_410: period_len = qcac_pkg::HALF_11 - 10'd1;
        endcase
        // Longer of the two code 01 periods, so alternation never cuts a period
        limit_len = (i_freq_sel == 2'h1) ? qcac_pkg::HALF_01 - 10'd1 : period_len;
    end

    // Down counter; a shortened selector ends the period at once if the count exceeds the new length
    always_comb
    begin
        nxt_start = 1'b0;
        nxt_cnt = cnt_ff - 10'd1;
        nxt_odd = odd_ff;
        if (cnt_ff == 10'd0 || cnt_ff > limit_len)
        begin
            nxt_cnt = period_len;
            nxt_start = 1'b1;
            nxt_odd = ~odd_ff;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_ff <= 10'd0;
            start_ff <= 1'b0;
            odd_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            start_ff <= nxt_start;
            odd_ff <= nxt_odd;
        end
    end

    assign o_period_start = start_ff;
endmodule : qcac_pwm_timer
`default_nettype wire

// ==== rtl/qcac_top.sv ====
// Purpose: Lower 19 bits of the quiet chopper PWM configuration word and amplitude path
// Assumes: Register writes/reads come as a strobe, 8-bit offset and 32-bit word
// Notes: Upper fields are held only to read back; regulation loop is outside
`default_nettype none
module qcac_top (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_WR_EN,
    input wire logic I_RD_EN,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_OTP_VALID,
    input wire logic [7:0] I_OTP_SLOPE,
    input wire logic [19:0] I_STEP_INTERVAL,
    input wire logic [4:0] I_CS_ACTUAL,
    input wire logic [7:0] I_REG_AMPLITUDE,
    input wire logic [7:0] I_LOW_THRESHOLD,
    input wire logic [7:0] I_TUNED_SLOPE,
    input wire logic I_TUNE_DONE,
    output logic [31:0] O_RDATA,
    output logic O_RVALID,
    output logic O_AUTOSCALE,
    output logic [1:0] O_FREQ_SEL,
    output logic O_PERIOD_START,
    output logic [7:0] O_AMPLITUDE,
    output logic [7:0] O_SLOPE_READBACK
);
    // ------------------------------------------------------------
    // Configuration word
    // ------------------------------------------------------------
    logic [7:0] ofs_ff, nxt_ofs;
    logic [7:0] slope_ff, nxt_slope;
    logic [1:0] freq_ff, nxt_freq;
    logic auto_ff, nxt_auto;
    logic [12:0] upper_ff, nxt_upper;
    logic otp_done_ff, nxt_otp_done;
    logic [7:0] tuned_ff, nxt_tuned;
    logic hit;

    assign hit = (I_ADDR == qcac_pkg::REG_OFFSET);

    // Writes, one-shot OTP seed and tuned capture
    always_comb
    begin
        nxt_ofs = ofs_ff;
        nxt_slope = slope_ff;
        nxt_freq = freq_ff;
        nxt_auto = auto_ff;
        nxt_upper = upper_ff;
        nxt_otp_done = otp_done_ff;
        nxt_tuned = tuned_ff;
        if (!otp_done_ff && I_OTP_VALID)
        begin
            nxt_slope = I_OTP_SLOPE;
            nxt_tuned = I_OTP_SLOPE;
            nxt_otp_done = 1'b1;
        end
        if (I_WR_EN && hit)
        begin
            nxt_ofs = I_WDATA[qcac_pkg::OFS_LSB +: 8];
            nxt_slope = I_WDATA[qcac_pkg::SLOPE_LSB +: 8];
            nxt_freq = I_WDATA[qcac_pkg::FREQ_LSB +: 2];
            nxt_auto = I_WDATA[qcac_pkg::AUTOSCALE_BIT];
            nxt_upper = I_WDATA[31:19];
            nxt_tuned = I_WDATA[qcac_pkg::SLOPE_LSB +: 8];
        end
        // Tuning result wins over a same-cycle write so it is not lost
        if (I_TUNE_DONE && auto_ff)
        begin
            nxt_tuned = I_TUNED_SLOPE;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ofs_ff <= qcac_pkg::OFS_RESET;
            slope_ff <= qcac_pkg::SLOPE_RESET;
            freq_ff <= qcac_pkg::FREQ_RESET;
            auto_ff <= qcac_pkg::AUTOSCALE_RESET;
            upper_ff <= 13'h0000;
            otp_done_ff <= 1'b0;
            tuned_ff <= qcac_pkg::SLOPE_RESET;
        end
        else
        begin
            ofs_ff <= nxt_ofs;
            slope_ff <= nxt_slope;
            freq_ff <= nxt_freq;
            auto_ff <= nxt_auto;
            upper_ff <= nxt_upper;
            otp_done_ff <= nxt_otp_done;
            tuned_ff <= nxt_tuned;
        end
    end

    // ------------------------------------------------------------
    // Amplitude path
    // ------------------------------------------------------------
    logic [15:0] velocity_term;
    logic [12:0] base_ff_term;
    logic [16:0] ff_sum;
    logic [8:0] reg_sum;
    logic [7:0] nxt_amp, amp_ff;
    logic [15:0] slope_x256;

    // Divide is combinational; slow area trade for a single-cycle update
    always_comb
    begin
        slope_x256 = {slope_ff, 8'h00};
        if (I_STEP_INTERVAL == 20'h0_0000)
        begin
            velocity_term = 16'hFFFF; // Zero interval saturates
        end
        else
        begin
            velocity_term = 16'(20'(slope_x256) / I_STEP_INTERVAL);
        end
        base_ff_term = 13'((13'(ofs_ff) * (13'(I_CS_ACTUAL) + 13'd1)) >> 5);
        ff_sum = 17'(base_ff_term) + 17'(velocity_term);
        reg_sum = 9'(I_REG_AMPLITUDE) + 9'(velocity_term[7:0]);
        if (!auto_ff)
        begin
            nxt_amp = (ff_sum > 17'(qcac_pkg::AMP_MAX)) ? qcac_pkg::AMP_MAX : ff_sum[7:0];
        end
        else
        begin
            if (velocity_term > 16'(qcac_pkg::AMP_MAX) || reg_sum[8])
            begin
                nxt_amp = qcac_pkg::AMP_MAX;
            end
            else
            begin
                nxt_amp = reg_sum[7:0];
            end
            // Zero offset: regulated amplitude floors at the threshold
            if (ofs_ff == 8'h00 && nxt_amp < I_LOW_THRESHOLD)
            begin
                nxt_amp = I_LOW_THRESHOLD;
            end
            // Nonzero offset leaves low duty cycles untouched
        end
    end

    // Amplitude updates on PWM period boundaries only
    logic period_start;
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            amp_ff <= 8'h00;
        end
        else if (period_start)
        begin
            amp_ff <= nxt_amp;
        end
    end

    qcac_pwm_timer u_timer (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_freq_sel(freq_ff),
        .o_period_start(period_start)
    );

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    logic [31:0] rdata_ff, nxt_rdata;
    logic rvalid_ff;
    logic pstart_ff;

    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (I_RD_EN)
        begin
            nxt_rdata = hit ? {upper_ff, auto_ff, freq_ff, slope_ff, ofs_ff} : 32'h0000_0000;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            rdata_ff <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
            pstart_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= I_RD_EN;
            pstart_ff <= period_start;
        end
    end

    assign O_RDATA = rdata_ff;
    assign O_RVALID = rvalid_ff;
    assign O_AUTOSCALE = auto_ff;
    assign O_FREQ_SEL = freq_ff;
    assign O_PERIOD_START = pstart_ff;
    assign O_AMPLITUDE = amp_ff;
    assign O_SLOPE_READBACK = tuned_ff;
endmodule : qcac_top
`default_nettype wire

// ==== tb/qcac_props.sv ====
// Purpose: Port-level checks of the chopper amplitude config block
// Assumes: One clock, async active-low reset
// Notes: Sees only top ports; bound after endmodule
`default_nettype none
module qcac_props (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_WR_EN,
    input wire logic I_RD_EN,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic [7:0] I_TUNED_SLOPE,
    input wire logic I_TUNE_DONE,
    input wire logic [31:0] O_RDATA,
    input wire logic O_RVALID,
    input wire logic O_AUTOSCALE,
    input wire logic [1:0] O_FREQ_SEL,
    input wire logic O_PERIOD_START,
    input wire logic [7:0] O_SLOPE_READBACK
);
    // ----------------------------------------
    // Access steps shared by the properties
    // ----------------------------------------
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    // Selector moves cut a running period short; spacing is judged away from them
    logic [1:0] freq_q_ff;
    logic [1:0] chg_ff;
    logic freq_edge;
    logic freq_moved;
    assign freq_edge = (O_FREQ_SEL != freq_q_ff);
    assign freq_moved = freq_edge || (chg_ff != 2'h0);
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            freq_q_ff <= qcac_pkg::FREQ_RESET;
            chg_ff <= 2'h0;
        end
        else
        begin
            freq_q_ff <= O_FREQ_SEL;
            chg_ff <= {chg_ff[0], freq_edge};
        end
    end
    sequence s_wr;
        I_WR_EN && I_ADDR == qcac_pkg::REG_OFFSET;
    endsequence
    sequence s_rd;
        I_RD_EN && I_ADDR == qcac_pkg::REG_OFFSET;
    endsequence
    // Answers, field updates and the period spacing
    a_rd_answer: assert property (s_rd |=> O_RVALID) else $error("read not answered");
    a_rvalid_pulse: assert property (!I_RD_EN |=> !O_RVALID) else $error("stray read valid");
    a_freq_write: assert property (s_wr |=> O_FREQ_SEL == $past(I_WDATA[17:16])) else $error("freq not taken");
    a_auto_write: assert property (s_wr |=> O_AUTOSCALE == $past(I_WDATA[18])) else $error("autoscale not taken");
    a_cfg_hold: assert property (!I_WR_EN |=> $stable(O_FREQ_SEL) && $stable(O_AUTOSCALE))
        else $error("config moved without write");
    a_slope_write: assert property (s_wr ##0 !I_TUNE_DONE |=> O_SLOPE_READBACK == $past(I_WDATA[15:8]))
        else $error("slope readback not written");
    a_tune_capture: assert property (I_TUNE_DONE && O_AUTOSCALE |=> O_SLOPE_READBACK == $past(I_TUNED_SLOPE))
        else $error("tuned slope lost");
    a_period_gap: assert property (O_PERIOD_START |=> (!O_PERIOD_START || freq_moved) [*8])
        else $error("period too short");
    a_rd_fields: assert property (s_rd ##0 !I_WR_EN |=> O_RDATA[18:16] == {O_AUTOSCALE, O_FREQ_SEL})
        else $error("read word disagrees");
endmodule : qcac_props
bind qcac_top qcac_props u_props (.I_CLK, .I_RST_B, .I_WR_EN, .I_RD_EN, .I_ADDR, .I_WDATA, .I_TUNED_SLOPE,
    .I_TUNE_DONE, .O_RDATA, .O_RVALID, .O_AUTOSCALE, .O_FREQ_SEL, .O_PERIOD_START, .O_SLOPE_READBACK);
`default_nettype wire

// ==== tb/qcac_top_bench.sv ====
// Purpose: Self-checking bench of the chopper amplitude config block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Amplitude checked only after two period pulses so the new word is latched
`default_nettype none
module qcac_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, otp_v = 0, tdone = 0, rvalid, auto, pstart;
    logic [7:0] addr = 8'h70, otp = 8'h5a, ramp = 8'h0a, thr = 8'h32, tslope = 8'h77, amp, sread;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [19:0] intv = 20'h0_0200;
    logic [4:0] cs = 5'h1f;
    logic [1:0] fsel;
    int mismatches = 0, samples_checked = 0;
    // Clocks in two periods: each code runs at 2/N of the clock
    int per[4] = '{1024, 683, 512, 410};
    always #4 clk = ~clk;
    qcac_top DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_WR_EN(wr), .I_RD_EN(rd), .I_ADDR(addr), .I_WDATA(wdata),
        .I_OTP_VALID(otp_v), .I_OTP_SLOPE(otp), .I_STEP_INTERVAL(intv), .I_CS_ACTUAL(cs), .I_REG_AMPLITUDE(ramp),
        .I_LOW_THRESHOLD(thr), .I_TUNED_SLOPE(tslope), .I_TUNE_DONE(tdone), .O_RDATA(rdata), .O_RVALID(rvalid),
        .O_AUTOSCALE(auto), .O_FREQ_SEL(fsel), .O_PERIOD_START(pstart), .O_AMPLITUDE(amp),
        .O_SLOPE_READBACK(sread));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr = a;
        wdata = d;
        wr = 1;
        tick(1);
        wr = 0;
        addr = 8'h70;
        tick(1);
    endtask : wr_reg
    task automatic rd_chk(input logic [31:0] exp);
        rd = 1;
        tick(1);
        rd = 0;
        check(rvalid, 1);
        check(rdata, exp);
    endtask : rd_chk
    // Bounded wait, so a dead timer cannot hang the run
    task automatic wait_ps(output int n);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (pstart !== 1'b1 && n < 1100);
    endtask : wait_ps
    task automatic amp_chk(input logic [31:0] word, input logic [7:0] exp);
        int n;
        wr_reg(8'h70, word);
        wait_ps(n);
        wait_ps(n);
        check(amp, exp);
    endtask : amp_chk
    // Two settling periods, then two whole ones; code 01 alternates lengths
    task automatic per_chk(input logic [1:0] c, input int exp);
        int n;
        int m;
        wr_reg(8'h70, {14'h0001, c, 16'h0024});
        wait_ps(n);
        wait_ps(n);
        wait_ps(n);
        wait_ps(m);
        check(n + m, exp);
    endtask : per_chk
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        tick(8);
        rst_b = 1;
        tick(1);
        rd_chk(32'h0004_0024);
        otp_v = 1;
        tick(2);
        rd_chk(32'h0004_5a24);
        tdone = 1;
        tick(1);
        tdone = 0;
        tick(1);
        check(sread, 8'h77);
        wr_reg(8'h70, 32'hfff4_3324);
        wr_reg(8'h71, 32'h0000_0000);
        rd_chk(32'hfff4_3324);
        check(sread, 8'h33);
        wr_reg(8'h70, 32'h0000_2a11);
        wr_reg(8'h70, 32'h0004_2a11);
        rd_chk(32'h0004_2a11);
        check(auto, 1'b1);
        check(fsel, 2'h0);
        check(sread, 8'h2a);
        amp_chk(32'h0003_0240, 8'h41);
        amp_chk(32'h0003_ffff, 8'hff);
        cs = 5'h0f;
        amp_chk(32'h0003_0240, 8'h21);
        amp_chk(32'h0007_0000, 8'h32);
        amp_chk(32'h0007_0001, 8'h0a);
        amp_chk(32'h0007_0401, 8'h0c);
        for (int c = 0; c < 4; c++)
            per_chk(2'(c), per[c]);
        print_verdict();
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #(40000 * 8);
        mismatches++;
        print_verdict();
    end
endmodule : qcac_top_bench
`default_nettype wire
